// File: logic/ohs_defines.vh
// Purpose: Shared constants of the receive overhead serial output ports.
// Assumes: A 50 MHz system clock and a 160 ns overhead output clock.
// Notes:   Definitions only; included by bare name.
`ifndef OHS_DEFINES_VH
`define OHS_DEFINES_VH

// System clock period and overhead output clock period, in ns.
`define OHS_SYS_PERIOD_NS   20
`define OHS_LINK_PERIOD_NS  160

// System cycles per overhead clock period, derived from the two periods.
`define OHS_DIV_CYC         (`OHS_LINK_PERIOD_NS / `OHS_SYS_PERIOD_NS)

// Divider phase at which the output clock falls and at which it rises.
`define OHS_FALL_AT         (`OHS_DIV_CYC / 2 - 1)
`define OHS_RISE_AT         (`OHS_DIV_CYC - 1)

// Lane numbers of the six serial ports.
`define OHS_LANE_DCC        0
`define OHS_LANE_OW         1
`define OHS_LANE_HI         2
`define OHS_LANE_CH0        3
`define OHS_NUM_LANES       6

// Lanes whose frame-start output spans the whole first byte.
`define OHS_FS_WHOLE_MASK   6'h3c

// Width of one FIFO word (frame-start flag plus byte) and FIFO depth.
`define OHS_FIFO_WIDTH      9
`define OHS_FIFO_DEPTH      8
`define OHS_FIFO_AW         3

// Bits per overhead byte less one, loaded into the bit counter.
`define OHS_BITS_LEFT_INIT  4'h7

`endif

// File: logic/ohs_fifo.v
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two and AW is its log2.
// Notes:   Full and empty come from a pointer pair one bit wider than AW.
`timescale 1ns/1ps
`default_nettype none

module ohs_fifo
#(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
)
(
    input  wire             i_sys_clk,
    input  wire             i_sys_rst,
    input  wire [WIDTH-1:0] i_wr_data,
    input  wire             i_wr_valid,
    output wire             o_wr_ready,
    output wire [WIDTH-1:0] o_rd_data,
    output wire             o_rd_valid,
    input  wire             i_rd_ready
);

    reg  [WIDTH-1:0] mem_q [0:DEPTH-1];  // Storage words, flip-flops.
    reg  [AW:0]      wr_ptr_q;           // Write pointer with wrap bit.
    reg  [AW:0]      rd_ptr_q;           // Read pointer with wrap bit.
    wire             full;               // All words hold data.
    wire             empty;              // No word holds data.
    wire             push;               // A word is accepted this cycle.
    wire             pop;                // A word is taken this cycle.

    // Equal pointers mean empty; only the wrap bit differing means full.
    assign empty      = (wr_ptr_q == rd_ptr_q);
    assign full       = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign o_wr_ready = ~full;
    assign o_rd_valid = ~empty;
    assign push       = i_wr_valid & ~full;
    assign pop        = i_rd_ready & ~empty;
    assign o_rd_data  = mem_q[rd_ptr_q[AW-1:0]];

    // Storage needs no reset; a word is only read after it was written.
    always @(posedge i_sys_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q[AW-1:0]] <= i_wr_data;
        end
    end

    // Pointers advance on accepted pushes and pops.
    always @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

endmodule // ohs_fifo

`default_nettype wire

// File: logic/ohs_ports.v
// Purpose: Receive overhead serial output ports (section DCC, order-wire,
//          high-order path overhead and three per-channel path overhead).
// Assumes: Upstream overhead processors deliver whole bytes with a flag
//          that marks the first byte of a frame (E1 or J1).
// Notes:   All output clocks are made here by dividing the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "ohs_defines.vh"

module ohs_ports
(
    input  wire        i_sys_clk,                      // 50 MHz system clock.
    input  wire        i_sys_rst,                      // Asynchronous reset, active high.
    input  wire [47:0] i_lane_byte,                    // Byte per lane, lane n at [8n+7:8n].
    input  wire [5:0]  i_lane_first,                   // First byte of a frame, per lane.
    input  wire [5:0]  i_lane_valid,                   // Byte offered, per lane.
    output wire [5:0]  o_lane_ready,                   // Byte accepted, per lane.
    output wire        o_transport_overhead_out_clock, // Clock of the DCC and order-wire ports.
    output wire        o_section_dcc_data_out,         // Serial section DCC data.
    output wire        o_section_dcc_valid_out,        // Section DCC bit valid.
    output wire        o_order_wire_data_out,          // Serial order-wire data.
    output wire        o_order_wire_valid_out,         // Order-wire bit valid.
    output wire        o_order_wire_frame_start,       // First bit of E1.
    output wire        o_hi_order_path_oh_clock,       // High-order path overhead clock.
    output wire        o_hi_order_path_oh_data,        // High-order path overhead data.
    output wire        o_hi_order_path_oh_frame_start, // High-order J1 byte marker.
    output wire        o_hi_order_path_oh_valid,       // High-order path data valid.
    output wire [2:0]  o_channel_path_oh_clock,        // Per-channel path overhead clocks.
    output wire [2:0]  o_channel_path_oh_data,         // Per-channel path overhead data.
    output wire [2:0]  o_channel_path_oh_frame_start,  // Per-channel J1 byte markers.
    output wire [2:0]  o_channel_path_oh_valid         // Per-channel path data valid.
);

    // The phases are worked out as integers and cut to the divider's
    // three bits on purpose; the divide ratio must therefore stay at eight.
    localparam integer FALL_INT = `OHS_FALL_AT;     // Falling-edge phase, full width.
    localparam integer RISE_INT = `OHS_RISE_AT;     // Rising-edge phase, full width.
    localparam [2:0] FALL_AT = FALL_INT[2:0];       // Divider phase of the falling edge.
    localparam [2:0] RISE_AT = RISE_INT[2:0];       // Divider phase of the rising edge.
    localparam [5:0] FS_WHOLE = `OHS_FS_WHOLE_MASK; // Lanes with byte-long frame start.

    reg  [2:0] div_q;      // Phase within one overhead clock period.
    reg  [5:0] oclk_q;     // One output clock register per port.
    wire       tick_fall;  // This edge drops every output clock.
    wire       tick_rise;  // This edge raises every output clock.
    wire [5:0] lane_data;  // Serial data of each lane.
    wire [5:0] lane_valid; // Valid indicator of each lane.
    wire [5:0] lane_fs;    // Frame-start indicator of each lane.

    assign tick_fall = (div_q == FALL_AT);
    assign tick_rise = (div_q == RISE_AT);

    // Free-running divider; the output clocks never stop, so the far end
    // always sees a rising edge to sample on, even while ports are idle.
    always @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            div_q <= 3'h0;
        end
        else
        begin
            div_q <= div_q + 3'h1;
        end
    end

    // Every port gets its own clock register, so a load or fault on one
    // clock pin cannot disturb the others. Reset leaves them high so the
    // first transition seen is a falling edge that carries data.
    always @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            oclk_q <= 6'h3f;
        end
        else if (tick_fall)
        begin
            oclk_q <= 6'h00;
        end
        else if (tick_rise)
        begin
            oclk_q <= 6'h3f;
        end
    end

    // True once no bit of the current byte remains behind the one on the
    // pin; both the fetch and the shifter decode it, so they cannot disagree.
    function byte_done;
        input [3:0] left;
        begin
            byte_done = (left == 4'h0);
        end
    endfunction

    // One lane per serial port: an input FIFO and a shifter that moves out
    // one bit, MSB first, at each falling output clock edge.
    genvar g;
    generate
        for (g = 0; g < `OHS_NUM_LANES; g = g + 1)
        begin : lane
            wire [8:0] fifo_out;   // Frame-start flag and byte at the FIFO head.
            wire       fifo_valid; // FIFO holds a byte.
            wire       load;       // Head byte is taken this edge.
            reg  [6:0] sh_q;       // Bits of the byte not yet on the pin.
            reg  [3:0] left_q;     // Bits still to follow the current one.
            reg        data_q;     // Bit on the pin.
            reg        valid_q;    // Valid indicator on the pin.
            reg        fs_q;       // Frame-start indicator on the pin.
            reg        fsb_q;      // Current byte opened a frame.

            ohs_fifo
            #(
                .WIDTH (`OHS_FIFO_WIDTH),
                .DEPTH (`OHS_FIFO_DEPTH),
                .AW    (`OHS_FIFO_AW)
            )
            u_fifo
            (
                .i_sys_clk  (i_sys_clk),
                .i_sys_rst  (i_sys_rst),
                .i_wr_data  ({i_lane_first[g], i_lane_byte[8*g+7:8*g]}),
                .i_wr_valid (i_lane_valid[g]),
                .o_wr_ready (o_lane_ready[g]),
                .o_rd_data  (fifo_out),
                .o_rd_valid (fifo_valid),
                .i_rd_ready (load)
            );

            // A new byte is fetched only at a falling edge after the last
            // bit of the previous one; bytes therefore run back to back.
            assign load = tick_fall && byte_done(left_q) && fifo_valid;

            // All pin registers move together, only on the falling edge.
            always @(posedge i_sys_clk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                begin
                    sh_q    <= 7'h00;
                    left_q  <= 4'h0;
                    data_q  <= 1'b0;
                    valid_q <= 1'b0;
                    fs_q    <= 1'b0;
                    fsb_q   <= 1'b0;
                end
                else if (tick_fall)
                begin
                    if (!byte_done(left_q))
                    begin
                        // Middle of a byte: next bit, valid stays high.
                        data_q  <= sh_q[6];
                        sh_q    <= {sh_q[5:0], 1'b0};
                        left_q  <= left_q - 4'h1;
                        valid_q <= 1'b1;
                        // Path ports mark the whole J1 byte; order-wire
                        // marks only the first bit of E1.
                        fs_q    <= fsb_q & FS_WHOLE[g];
                    end
                    else if (fifo_valid)
                    begin
                        // First bit of a fresh byte.
                        data_q  <= fifo_out[7];
                        sh_q    <= fifo_out[6:0];
                        left_q  <= `OHS_BITS_LEFT_INIT;
                        valid_q <= 1'b1;
                        fs_q    <= fifo_out[8];
                        fsb_q   <= fifo_out[8];
                    end
                    else
                    begin
                        // Nothing to send: indicators drop, data parks low.
                        data_q  <= 1'b0;
                        valid_q <= 1'b0;
                        fs_q    <= 1'b0;
                        fsb_q   <= 1'b0;
                    end
                end
            end

            assign lane_data[g]  = data_q;
            assign lane_valid[g] = valid_q;
            assign lane_fs[g]    = fs_q;
        end
    endgenerate

    // Section DCC port; the far end latches a bit at each rising edge
    // with valid high, which the half-period setup here allows.
    assign o_transport_overhead_out_clock = oclk_q[`OHS_LANE_DCC];
    assign o_section_dcc_data_out         = lane_data[`OHS_LANE_DCC];
    assign o_section_dcc_valid_out        = lane_valid[`OHS_LANE_DCC];

    // Order-wire port shares the transport overhead clock by design; its
    // own clock register mirrors the DCC one exactly.
    assign o_order_wire_data_out    = lane_data[`OHS_LANE_OW];
    assign o_order_wire_valid_out   = lane_valid[`OHS_LANE_OW];
    assign o_order_wire_frame_start = lane_fs[`OHS_LANE_OW];

    // High-order path overhead port with its own clock.
    assign o_hi_order_path_oh_clock       = oclk_q[`OHS_LANE_HI];
    assign o_hi_order_path_oh_data        = lane_data[`OHS_LANE_HI];
    assign o_hi_order_path_oh_frame_start = lane_fs[`OHS_LANE_HI];
    assign o_hi_order_path_oh_valid       = lane_valid[`OHS_LANE_HI];

    // Three independent per-channel path overhead ports.
    assign o_channel_path_oh_clock       = oclk_q[`OHS_LANE_CH0+2:`OHS_LANE_CH0];
    assign o_channel_path_oh_data        = lane_data[`OHS_LANE_CH0+2:`OHS_LANE_CH0];
    assign o_channel_path_oh_frame_start = lane_fs[`OHS_LANE_CH0+2:`OHS_LANE_CH0];
    assign o_channel_path_oh_valid       = lane_valid[`OHS_LANE_CH0+2:`OHS_LANE_CH0];

endmodule // ohs_ports

`default_nettype wire

// File: tb/ohs_ports_assertions.sv
// Purpose: Timing checks on the serial overhead output ports.
// Assumes: All output clocks share one phase, eight system cycles long.
// Notes:   Byte-long spans are judged by the bench's far-end models.
`timescale 1ns/1ps
`default_nettype none
module ohs_ports_assertions
(
    input wire logic        i_sys_clk,
    input wire logic        i_sys_rst,
    input wire logic [47:0] i_lane_byte,
    input wire logic [5:0]  i_lane_first,
    input wire logic [5:0]  i_lane_valid,
    input wire logic [5:0]  o_lane_ready,
    input wire logic        o_transport_overhead_out_clock,
    input wire logic        o_section_dcc_data_out,
    input wire logic        o_section_dcc_valid_out,
    input wire logic        o_order_wire_data_out,
    input wire logic        o_order_wire_valid_out,
    input wire logic        o_order_wire_frame_start,
    input wire logic        o_hi_order_path_oh_clock,
    input wire logic        o_hi_order_path_oh_data,
    input wire logic        o_hi_order_path_oh_frame_start,
    input wire logic        o_hi_order_path_oh_valid,
    input wire logic [2:0]  o_channel_path_oh_clock,
    input wire logic [2:0]  o_channel_path_oh_data,
    input wire logic [2:0]  o_channel_path_oh_frame_start,
    input wire logic [2:0]  o_channel_path_oh_valid
);
    // Every check runs on the system clock and sleeps while reset is high.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // The output clock must run four cycles low, then four high.
    toh_period_a: assert property ($fell(o_transport_overhead_out_clock) |->
        (!o_transport_overhead_out_clock)[*4] ##1 o_transport_overhead_out_clock[*4] ##1
        !o_transport_overhead_out_clock) else $error("overhead clock period wrong");
    // Outputs move only where the far end cannot be sampling them.
    dcc_on_fall_a: assert property ($changed({o_section_dcc_data_out, o_section_dcc_valid_out}) |->
        $fell(o_transport_overhead_out_clock)) else $error("dcc changed off clock fall");
    ow_on_fall_a: assert property ($changed({o_order_wire_data_out, o_order_wire_valid_out,
        o_order_wire_frame_start}) |-> $fell(o_transport_overhead_out_clock)) else $error("ow off fall");
    hi_on_fall_a: assert property ($changed({o_hi_order_path_oh_data, o_hi_order_path_oh_frame_start,
        o_hi_order_path_oh_valid}) |-> $fell(o_hi_order_path_oh_clock)) else $error("hi path off fall");
    ch_on_fall_a: assert property ($changed({o_channel_path_oh_data, o_channel_path_oh_frame_start,
        o_channel_path_oh_valid}) |-> o_channel_path_oh_clock == 3'h0 && $past(o_channel_path_oh_clock) == 3'h7)
        else $error("channel path off fall");
    // A valid bit stands at least one whole output period; the order-wire frame start stands exactly one.
    dcc_valid_hold_a: assert property ($rose(o_section_dcc_valid_out) |-> o_section_dcc_valid_out[*8])
        else $error("dcc valid too short");
    ow_valid_hold_a: assert property ($rose(o_order_wire_valid_out) |-> o_order_wire_valid_out[*8])
        else $error("ow valid too short");
    ow_fs_once_a: assert property ($rose(o_order_wire_frame_start) |->
        (o_order_wire_frame_start && o_order_wire_valid_out)[*8] ##1 !o_order_wire_frame_start)
        else $error("ow frame start not one period");
    // A frame marker without data would mislead the far end.
    hi_fs_valid_a: assert property (o_hi_order_path_oh_frame_start |-> o_hi_order_path_oh_valid)
        else $error("hi frame start without valid");
    ch_fs_valid_a: assert property ((o_channel_path_oh_frame_start & ~o_channel_path_oh_valid) == 3'h0)
        else $error("channel frame start without valid");
endmodule // ohs_ports_assertions
bind ohs_ports ohs_ports_assertions i_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_lane_byte(i_lane_byte), .i_lane_first(i_lane_first), .i_lane_valid(i_lane_valid),
    .o_lane_ready(o_lane_ready), .o_transport_overhead_out_clock(o_transport_overhead_out_clock),
    .o_section_dcc_data_out(o_section_dcc_data_out), .o_section_dcc_valid_out(o_section_dcc_valid_out),
    .o_order_wire_data_out(o_order_wire_data_out), .o_order_wire_valid_out(o_order_wire_valid_out),
    .o_order_wire_frame_start(o_order_wire_frame_start), .o_hi_order_path_oh_clock(o_hi_order_path_oh_clock),
    .o_hi_order_path_oh_data(o_hi_order_path_oh_data), .o_hi_order_path_oh_valid(o_hi_order_path_oh_valid),
    .o_hi_order_path_oh_frame_start(o_hi_order_path_oh_frame_start),
    .o_channel_path_oh_clock(o_channel_path_oh_clock), .o_channel_path_oh_data(o_channel_path_oh_data),
    .o_channel_path_oh_frame_start(o_channel_path_oh_frame_start),
    .o_channel_path_oh_valid(o_channel_path_oh_valid));
`default_nettype wire

// File: tb/ohs_far_end.sv
// Purpose: Far-end capture logic for one serial overhead port.
// Assumes: Bits arrive MSB first, eight to a byte.
// Notes:   No reset; a reset of the port mid-byte misaligns it.
`timescale 1ns/1ps
`default_nettype none
module ohs_far_end
(
    input  wire logic       i_lnk_clk,
    input  wire logic       i_lnk_data,
    input  wire logic       i_lnk_valid,
    input  wire logic       i_lnk_fs,
    output var  logic [7:0] o_byte,
    output var  logic [7:0] o_count,
    output var  logic [3:0] o_fs_bits
);
    logic [7:0] sh_q;   // Bits gathered so far.
    logic [3:0] bits_q; // Bits of the current byte.
    logic [3:0] fs_q;   // Frame-start bits seen in it.
    initial {sh_q, bits_q, fs_q, o_byte, o_count, o_fs_bits} = '0;
    // Latch a bit only when valid is seen high at the rising edge.
    always @(posedge i_lnk_clk)
    begin
        if (i_lnk_valid)
        begin
            sh_q <= {sh_q[6:0], i_lnk_data};
            bits_q <= bits_q + 4'h1;
            fs_q <= fs_q + {3'h0, i_lnk_fs};
            if (bits_q == 4'h7) // A whole byte is in.
            begin
                o_byte <= {sh_q[6:0], i_lnk_data};
                o_count <= o_count + 8'h01;
                o_fs_bits <= fs_q + {3'h0, i_lnk_fs};
                bits_q <= 4'h0;
                fs_q <= 4'h0;
            end
        end
    end
endmodule // ohs_far_end
`default_nettype wire

// File: tb/rx_overhead_serial_ports_bench.sv
// Purpose: Self-checking bench of the serial overhead output ports.
// Assumes: Stimulus changes at the falling system clock edge.
// Notes:   Rows send one byte each; fill and reset are tested after.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module rx_overhead_serial_ports_bench;
    logic        clk = 1'b0, rst = 1'b1;   // System clock and reset.
    logic [47:0] lb = '0;                  // Lane bytes.
    logic [5:0]  lf = '0, lv = '0;         // Lane first flags and valids.
    wire  [5:0]  rdy, lk_clk, lk_dat, lk_val, lk_fs;
    wire  [2:0]  cc, cd, cf, cv;
    wire         tc, dd, dv, od, ov, of, hc, hd, hf, hv;
    wire  [7:0]  cap_b [0:5], cap_n [0:5]; // Captured byte and byte count.
    wire  [3:0]  cap_f [0:5];              // Frame-start bits of that byte.
    int          checked = 0, err_total = 0, acc, low;
    logic [7:0]  old;
    // Rows: lane, byte, first flag, frame-start bits expected at the far end.
    logic [19:0] rows [0:7] = '{20'h0a510, 20'h13c11, 20'h1c300, 20'h28118,
                                20'h27e00, 20'h35a18, 20'h4e718, 20'h51800};
    always #10 clk = ~clk;
    assign lk_clk = {cc, hc, tc, tc};
    assign lk_dat = {cd, hd, od, dd};
    assign lk_val = {cv, hv, ov, dv};
    assign lk_fs  = {cf, hf, of, 1'b0};    // The DCC port has no frame marker.
    ohs_ports i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_lane_byte(lb), .i_lane_first(lf),
        .i_lane_valid(lv), .o_lane_ready(rdy), .o_transport_overhead_out_clock(tc),
        .o_section_dcc_data_out(dd), .o_section_dcc_valid_out(dv), .o_order_wire_data_out(od),
        .o_order_wire_valid_out(ov), .o_order_wire_frame_start(of), .o_hi_order_path_oh_clock(hc),
        .o_hi_order_path_oh_data(hd), .o_hi_order_path_oh_frame_start(hf), .o_hi_order_path_oh_valid(hv),
        .o_channel_path_oh_clock(cc), .o_channel_path_oh_data(cd),
        .o_channel_path_oh_frame_start(cf), .o_channel_path_oh_valid(cv));
    // One far-end model per port.
    for (genvar g = 0; g < 6; g++)
    begin : g_far
        ohs_far_end i_far (.i_lnk_clk(lk_clk[g]), .i_lnk_data(lk_dat[g]), .i_lnk_valid(lk_val[g]),
            .i_lnk_fs(lk_fs[g]), .o_byte(cap_b[g]), .o_count(cap_n[g]), .o_fs_bits(cap_f[g]));
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Offer a byte; ready seen at the falling edge means the next rise takes it.
    task automatic send(input int ln, input logic [7:0] b, input logic f);
        int n;
        n = 0;
        @(negedge clk);
        lb[8*ln +: 8] = b;
        lf[ln] = f;
        lv[ln] = 1'b1;
        while (rdy[ln] !== 1'b1 && n < 200) begin @(negedge clk); n++; end
        if (n == 200) begin err_total++; end_of_test; end
        @(negedge clk);
        lv[ln] = 1'b0;
    endtask
    // Wait, bounded, until the far end of a lane holds a given count.
    task automatic wait_cap(input int ln, input logic [7:0] want, input int lim);
        int n;
        n = 0;
        while (cap_n[ln] !== want && n < lim) begin @(negedge clk); n++; end
        if (n == lim) begin err_total++; end_of_test; end
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        `CHK("ready after reset", 6'h3f, rdy)
        `CHK("valids after reset", 6'h00, lk_val)
        `CHK("clocks after reset", 6'h3f, lk_clk)
        repeat (3) @(negedge clk);
        `CHK("clocks before fall", 6'h3f, lk_clk)
        @(negedge clk);
        `CHK("clocks after fall", 6'h00, lk_clk)
        foreach (rows[i])
        begin
            old = cap_n[rows[i][19:16]];
            send(rows[i][19:16], rows[i][15:8], rows[i][4]);
            wait_cap(rows[i][19:16], old + 8'h01, 300);
            `CHK("byte", rows[i][15:8], cap_b[rows[i][19:16]])
            `CHK("frame bits", rows[i][3:0], cap_f[rows[i][19:16]])
        end
        // Hold a lane offered for 12 cycles, long enough for the FIFO to refuse, then let it drain.
        old = cap_n[5];
        acc = 0;
        low = 0;
        @(negedge clk);
        lb[47:40] = 8'h96;
        lv[5] = 1'b1;
        repeat (12) begin if (rdy[5] === 1'b1) acc++; else low = 1; @(negedge clk); end
        lv[5] = 1'b0;
        `CHK("refused when full", 1, low)
        wait_cap(5, old + 8'(acc), 1200);
        `CHK("last byte", 8'h96, cap_b[5])
        repeat (16) @(negedge clk);
        `CHK("idle valid", 3'h0, cv)
        // Reset in the middle of a byte clears every indicator.
        send(2, 8'hf0, 1'b1);
        repeat (40) @(negedge clk);
        `CHK("valid mid byte", 1'b1, hv)
        rst = 1'b1;
        @(negedge clk);
        `CHK("valids in reset", 6'h00, lk_val | lk_fs)
        rst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("valids after second reset", 6'h00, lk_val | lk_fs)
        `CHK("clocks after second reset", 6'h3f, lk_clk)
        `CHK("ready after second reset", 6'h3f, rdy)
        end_of_test;
    end
endmodule // rx_overhead_serial_ports_bench
`default_nettype wire
